// >>> pkg/ssps_pkg.sv
// constants and types shared by the strap capture and serial pin select block
package ssps_pkg;
    // positions inside the synchronised pin vector
    localparam int SYN_W = 13;
    localparam int SYN_HOST_STRAP = 0;
    localparam int SYN_SEL = 1;
    localparam int SYN_SCK = 2;
    localparam int SYN_HOST_DATA = 3;
    localparam int SYN_SLAVE_OUT = 4;
    localparam int SYN_CONSOLE_TX = 5;
    localparam int SYN_FLASH_SEL = 6;
    localparam int SYN_TEST_OUT = 7;
    localparam int SYN_FLASH_DIN = 8;
    localparam int SYN_CONSOLE_RX = 9;
    localparam int SYN_TEST_RST_N = 10;
    localparam int SYN_TEST_CLK = 11;
    localparam int SYN_TEST_DIN = 12;
    // strap values shown before the first capture
    localparam logic HOST_MODE_RST = 1'b1;
    localparam logic ENERGY_RST = 1'b1;
    localparam logic LAMP_SEL_RST = 1'b0;
    localparam logic LOOP_DET_RST = 1'b0;
    localparam logic MICRO_EN_RST = 1'b1;
    // lamp pins sink current, so a lit lamp is a low level
    localparam logic LAMP_ON_LEVEL = 1'b0;
    localparam int LAMP_W = 8;
    localparam int SYNC_STAGES = 2;
    // cycles after release before straps are taken: covers the synchroniser
    localparam int STRAP_SETTLE_CYC = 4;
    localparam int CNT_W = 3;
    localparam int TEST_SHIFT_W = 8;
    typedef enum logic [1:0] {
        SSPS_HOLD,
        SSPS_SETTLE,
        SSPS_RUN
    } ssps_state_e;
endpackage

// >>> core/ssps_sync.sv
// two flip-flop synchroniser for a vector of independent pin levels
`timescale 1ns/10ps
`default_nettype none
module ssps_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                end
                else
                begin
                    meta_q[i] <= async_in[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate
    assign sync_out = sync_q;
endmodule // ssps_sync
`default_nettype wire

// >>> core/ssps_pin_select.sv
// power-on strap capture and function select for serial, flash, test and console pins
`timescale 1ns/10ps
`default_nettype none
// Function
// - sample host/memory strap; high means slave port
// - slave port answers only while select low
// - memory master drives select high to read
// - slave shifts read data out, takes input
// - host data pin floats during reset
// - energy strap from slave-out pin, default one
// - lamp strap moves uplink pins to lamps
// - flash chip select is active low
// - loop-detect strap from flash select pin
// - flash clock, data out, data in
// - test reset low resets test controller
// - test data captured on test clock rise
// - microcontroller strap from test-out pin
// - lamp outputs are fixed active low
module ssps_pin_select
    import ssps_pkg::*;
#(
    parameter int LAMPS = ssps_pkg::LAMP_W,
    parameter int SHIFT_W = ssps_pkg::TEST_SHIFT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic host_mem_strap_pin,
    input wire logic serial_sel_in,
    output logic serial_sel_out,
    output logic serial_sel_oe,
    input wire logic serial_clk_in,
    output logic serial_clk_out,
    output logic serial_clk_oe,
    input wire logic host_data_in,
    output logic host_data_out,
    output logic host_data_oe,
    input wire logic slave_out_energy_strap_pin_in,
    output logic slave_out_energy_strap_pin_out,
    output logic slave_out_energy_strap_pin_oe,
    input wire logic console_tx_lamp_strap_pin_in,
    output logic console_tx_lamp_strap_pin_out,
    output logic console_tx_lamp_strap_pin_oe,
    input wire logic console_receive,
    output logic [LAMPS-1:0] uplink_pin_out,
    output logic flash_clock_out,
    input wire logic flash_select_loop_strap_pin_in,
    output logic flash_select_loop_strap_pin_out,
    output logic flash_select_loop_strap_pin_oe,
    input wire logic flash_data_in,
    output logic flash_data_out,
    input wire logic test_reset_n,
    input wire logic test_clk,
    input wire logic test_data_in,
    input wire logic test_out_micro_strap_pin_in,
    output logic test_out_micro_strap_pin_out,
    output logic test_out_micro_strap_pin_oe,
    input wire logic core_slave_tx_data,
    input wire logic core_slave_tx_en,
    input wire logic core_mem_read,
    input wire logic core_mem_clk,
    input wire logic core_mem_data,
    input wire logic core_console_tx,
    input wire logic [LAMPS-1:0] core_uplink_data,
    input wire logic [LAMPS-1:0] core_lamp_on,
    input wire logic core_flash_clk,
    input wire logic core_flash_select,
    input wire logic core_flash_data,
    input wire logic core_test_out,
    input wire logic core_test_out_en,
    output logic straps_valid,
    output logic host_mode,
    output logic energy_saving_strap,
    output logic uplink_lamp_select,
    output logic loop_detect_strap,
    output logic micro_enable,
    output logic slave_selected,
    output logic slave_clk,
    output logic slave_data_in,
    output logic mem_data_in,
    output logic console_rx,
    output logic flash_din,
    output logic test_ctrl_in_reset,
    output logic [SHIFT_W-1:0] test_shift
);
    import ssps_pkg::*;

    logic [SYN_W-1:0] pins_raw;
    logic [SYN_W-1:0] pins_s;
    assign pins_raw = {test_data_in, test_clk, test_reset_n, console_receive, flash_data_in,
        test_out_micro_strap_pin_in, flash_select_loop_strap_pin_in,
        console_tx_lamp_strap_pin_in, slave_out_energy_strap_pin_in, host_data_in,
        serial_clk_in, serial_sel_in, host_mem_strap_pin};

    ssps_sync #(
        .WIDTH(SYN_W)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    // control group: power-on sequence, straps, test capture
    ssps_state_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic host_q, host_d, energy_q, energy_d, lamp_q, lamp_d;
    logic loop_q, loop_d, micro_q, micro_d, valid_q, valid_d;
    logic tck_prev_q, tck_prev_d, tap_rst_q, tap_rst_d;
    logic [SHIFT_W-1:0] shift_q, shift_d;
    logic tck_rise;

    assign tck_rise = pins_s[SYN_TEST_CLK] & ~tck_prev_q;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        host_d = host_q;
        energy_d = energy_q;
        lamp_d = lamp_q;
        loop_d = loop_q;
        micro_d = micro_q;
        valid_d = valid_q;
        case (state_q)
            SSPS_HOLD:
            begin
                state_d = SSPS_SETTLE;
                cnt_d = '0;
            end
            SSPS_SETTLE:
            begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(STRAP_SETTLE_CYC - 1))
                begin
                    state_d = SSPS_RUN;
                    valid_d = 1'b1;
                    host_d = pins_s[SYN_HOST_STRAP];
                    energy_d = pins_s[SYN_SLAVE_OUT];
                    lamp_d = pins_s[SYN_CONSOLE_TX];
                    loop_d = pins_s[SYN_FLASH_SEL];
                    micro_d = pins_s[SYN_TEST_OUT];
                end
            end
            // straps are never touched again here until rst
            SSPS_RUN: state_d = SSPS_RUN;
            default: state_d = SSPS_HOLD;
        endcase
        tck_prev_d = pins_s[SYN_TEST_CLK];
        tap_rst_d = ~pins_s[SYN_TEST_RST_N];
        shift_d = shift_q;
        if (~pins_s[SYN_TEST_RST_N])
            shift_d = '0;
        else if (tck_rise)
            shift_d = {shift_q[SHIFT_W-2:0], pins_s[SYN_TEST_DIN]};
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= SSPS_HOLD;
            cnt_q <= '0;
            host_q <= HOST_MODE_RST;
            energy_q <= ENERGY_RST;
            lamp_q <= LAMP_SEL_RST;
            loop_q <= LOOP_DET_RST;
            micro_q <= MICRO_EN_RST;
            valid_q <= 1'b0;
            tck_prev_q <= 1'b0;
            tap_rst_q <= 1'b1;
            shift_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            host_q <= host_d;
            energy_q <= energy_d;
            lamp_q <= lamp_d;
            loop_q <= loop_d;
            micro_q <= micro_d;
            valid_q <= valid_d;
            tck_prev_q <= tck_prev_d;
            tap_rst_q <= tap_rst_d;
            shift_q <= shift_d;
        end
    end

    // pin group: every pin and core-side output is registered
    logic run;
    logic [14:0] pin_d, pin_q;
    logic [LAMPS-1:0] uplink_d, uplink_q;
    logic [6:0] oe_d, oe_q;
    assign run = (state_q == SSPS_RUN);

    always_comb
    begin
        pin_d = '0;
        oe_d = '0;
        if (run)
        begin
            if (host_q)
            begin
                pin_d[0] = core_slave_tx_data;
                oe_d[3] = core_slave_tx_en & ~pins_s[SYN_SEL];
            end
            else
            begin
                pin_d[1] = core_mem_read;
                pin_d[2] = core_mem_clk;
                pin_d[3] = core_mem_data;
                oe_d[0] = 1'b1;
                oe_d[1] = 1'b1;
                oe_d[2] = 1'b1;
            end
            oe_d[4] = 1'b1;
            oe_d[5] = 1'b1;
            oe_d[6] = core_test_out_en;
            pin_d[4] = core_console_tx;
            pin_d[5] = ~core_flash_select;
            pin_d[6] = core_test_out;
            pin_d[7] = core_flash_clk;
            pin_d[8] = core_flash_data;
        end
        pin_d[9] = host_q & run & ~pins_s[SYN_SEL];
        pin_d[10] = host_q & pins_s[SYN_SCK];
        pin_d[11] = host_q & pins_s[SYN_HOST_DATA];
        pin_d[12] = ~host_q & pins_s[SYN_SLAVE_OUT];
        pin_d[13] = pins_s[SYN_CONSOLE_RX];
        pin_d[14] = pins_s[SYN_FLASH_DIN];
        // lamp drive inverted: lit lamp pulls the pin low
        uplink_d = lamp_q ? ~core_lamp_on : core_uplink_data;
        if (!run)
            uplink_d = '0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pin_q <= '0;
            oe_q <= '0;
            uplink_q <= '0;
        end
        else
        begin
            pin_q <= pin_d;
            oe_q <= oe_d;
            uplink_q <= uplink_d;
        end
    end

    assign slave_out_energy_strap_pin_out = pin_q[0];
    assign serial_sel_out = pin_q[1];
    assign serial_clk_out = pin_q[2];
    assign host_data_out = pin_q[3];
    assign console_tx_lamp_strap_pin_out = pin_q[4];
    assign flash_select_loop_strap_pin_out = pin_q[5];
    assign test_out_micro_strap_pin_out = pin_q[6];
    assign flash_clock_out = pin_q[7];
    assign flash_data_out = pin_q[8];
    assign slave_selected = pin_q[9];
    assign slave_clk = pin_q[10];
    assign slave_data_in = pin_q[11];
    assign mem_data_in = pin_q[12];
    assign console_rx = pin_q[13];
    assign flash_din = pin_q[14];
    assign serial_sel_oe = oe_q[0];
    assign serial_clk_oe = oe_q[1];
    assign host_data_oe = oe_q[2];
    assign slave_out_energy_strap_pin_oe = oe_q[3];
    assign console_tx_lamp_strap_pin_oe = oe_q[4];
    assign flash_select_loop_strap_pin_oe = oe_q[5];
    assign test_out_micro_strap_pin_oe = oe_q[6];
    assign uplink_pin_out = uplink_q;
    assign straps_valid = valid_q;
    assign host_mode = host_q;
    assign energy_saving_strap = energy_q;
    assign uplink_lamp_select = lamp_q;
    assign loop_detect_strap = loop_q;
    assign micro_enable = micro_q;
    assign test_ctrl_in_reset = tap_rst_q;
    assign test_shift = shift_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    strap_capture_a: assert property (state_q == SSPS_SETTLE && state_d == SSPS_RUN |=>
        host_q == $past(pins_s[SYN_HOST_STRAP]) && energy_q == $past(pins_s[SYN_SLAVE_OUT]))
        else $error("strap not captured at settle end");
    strap_hold_a: assert property (valid_q |=> $stable(host_q) && $stable(energy_q)
        && $stable(lamp_q) && $stable(loop_q) && $stable(micro_q))
        else $error("strap changed after capture");
    slave_quiet_a: assert property (host_q && pins_s[SYN_SEL] |=> !oe_q[3])
        else $error("slave output driven while deselected");
    mem_select_a: assert property (run && !host_q && core_mem_read |=> serial_sel_out
        && serial_sel_oe)
        else $error("memory select not driven high");
    data_float_a: assert property ($rose(run) |-> $past(!host_data_oe, 1))
        else $error("host data pin driven before run");
    flash_sel_a: assert property (run && core_flash_select |=> !flash_select_loop_strap_pin_out)
        else $error("flash select not active low");
    test_reset_a: assert property (!pins_s[SYN_TEST_RST_N] |=> shift_q == '0 && tap_rst_q)
        else $error("test controller not reset");
    test_shift_a: assert property (pins_s[SYN_TEST_RST_N] && tck_rise |=>
        shift_q[0] == $past(pins_s[SYN_TEST_DIN]))
        else $error("test data not captured on clock rise");
    // whole lamp vector: a lit lamp must show the lit level on every pin
    lamp_level_a: assert property (run && lamp_q |=>
        uplink_pin_out == ($past(core_lamp_on) ^ {LAMPS{~LAMP_ON_LEVEL}}))
        else $error("lamp polarity wrong");
    settle_len_a: assert property ($rose(state_q == SSPS_SETTLE) |->
        (state_q == SSPS_SETTLE) [*4] ##1 run)
        else $error("settle length wrong");

    cov_slave_c: cover property (run && host_q && slave_selected);
    cov_master_c: cover property (run && !host_q && serial_sel_out);
    cov_lamp_c: cover property (run && lamp_q);
    cov_test_c: cover property (tck_rise && pins_s[SYN_TEST_RST_N]);
endmodule // ssps_pin_select
`default_nettype wire

// >>> verification/ssps_far_model.sv
// far side model: host processor or configuration memory, plus the board strap resistors
`timescale 1ns/10ps
`default_nettype none
module ssps_far_model (
    input wire logic [4:0] cfg,
    input wire logic host_sel_n,
    input wire logic host_sck,
    input wire logic host_mosi,
    input wire logic mem_talk,
    input wire logic mem_bit,
    input wire logic [6:0] pin_out,
    input wire logic [6:0] pin_oe,
    output logic strap_pin,
    output logic [6:0] pin
);
    logic [6:0] idle;
    logic sel_lvl;
    // a host is fitted only when the board straps slave mode
    assign strap_pin = cfg[4];
    always_comb
    begin
        idle[0] = cfg[4] ? host_sel_n : 1'b1;
        idle[1] = cfg[4] & host_sck;
        idle[2] = cfg[4] ? host_mosi : 1'b1;
        sel_lvl = pin_oe[0] ? pin_out[0] : idle[0];
        // memory talks only while selected; otherwise the strap resistor wins
        idle[3] = (!cfg[4] && mem_talk && sel_lvl) ? mem_bit : cfg[3];
        idle[4] = cfg[2];
        idle[5] = cfg[1];
        idle[6] = cfg[0];
    end
    assign pin = (pin_oe & pin_out) | (~pin_oe & idle);
endmodule // ssps_far_model
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for strap capture and serial pin select
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk, rst = 1'b1, console_receive = 1'b1, flash_data_in = 1'b0;
    logic test_reset_n = 1'b0, test_clk = 1'b0, test_data_in = 1'b0;
    logic core_slave_tx_data = 1'b0, core_slave_tx_en = 1'b0, core_mem_read = 1'b0;
    logic core_mem_clk = 1'b0, core_mem_data = 1'b0, core_console_tx = 1'b0;
    logic [7:0] core_uplink_data = 8'h00, core_lamp_on = 8'h00, test_shift, uplink_pin_out;
    logic core_flash_clk = 1'b0, core_flash_select = 1'b0, core_flash_data = 1'b0;
    logic core_test_out = 1'b0, core_test_out_en = 1'b0;
    logic [4:0] cfg = 5'h16;
    logic host_sel_n = 1'b1, host_sck = 1'b0, host_mosi = 1'b0, mem_talk = 1'b0, mem_bit = 1'b0;
    wire logic [6:0] po, poe, pin;
    logic strap, straps_valid, host_mode, energy_saving_strap, uplink_lamp_select;
    logic loop_detect_strap, micro_enable, slave_selected, slave_clk, slave_data_in;
    logic mem_data_in, console_rx, flash_din, test_ctrl_in_reset, flash_clock_out, flash_data_out;
    int n_errors = 0, n_checks = 0, cyc = 0;
    ssps_far_model ssps_far_model_i (.cfg, .host_sel_n, .host_sck, .host_mosi, .mem_talk,
        .mem_bit, .pin_out(po), .pin_oe(poe), .strap_pin(strap), .pin);
    ssps_pin_select ssps_pin_select_i (.clk, .rst, .host_mem_strap_pin(strap),
        .serial_sel_in(pin[0]), .serial_sel_out(po[0]), .serial_sel_oe(poe[0]),
        .serial_clk_in(pin[1]), .serial_clk_out(po[1]), .serial_clk_oe(poe[1]),
        .host_data_in(pin[2]), .host_data_out(po[2]), .host_data_oe(poe[2]),
        .slave_out_energy_strap_pin_in(pin[3]), .slave_out_energy_strap_pin_out(po[3]),
        .slave_out_energy_strap_pin_oe(poe[3]), .console_tx_lamp_strap_pin_in(pin[4]),
        .console_tx_lamp_strap_pin_out(po[4]), .console_tx_lamp_strap_pin_oe(poe[4]),
        .flash_select_loop_strap_pin_in(pin[5]), .flash_select_loop_strap_pin_out(po[5]),
        .flash_select_loop_strap_pin_oe(poe[5]), .test_out_micro_strap_pin_in(pin[6]),
        .test_out_micro_strap_pin_out(po[6]), .test_out_micro_strap_pin_oe(poe[6]),
        .console_receive, .uplink_pin_out, .flash_clock_out, .flash_data_in, .flash_data_out,
        .test_reset_n, .test_clk, .test_data_in, .core_slave_tx_data, .core_slave_tx_en,
        .core_mem_read, .core_mem_clk, .core_mem_data, .core_console_tx, .core_uplink_data,
        .core_lamp_on, .core_flash_clk, .core_flash_select, .core_flash_data, .core_test_out,
        .core_test_out_en, .straps_valid, .host_mode, .energy_saving_strap, .uplink_lamp_select,
        .loop_detect_strap, .micro_enable, .slave_selected, .slave_clk, .slave_data_in,
        .mem_data_in, .console_rx, .flash_din, .test_ctrl_in_reset, .test_shift);
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task test_done;
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // a hung wait must still reach the verdict
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            test_done;
        end
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // sample just past the edge so the edge's updates have landed
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task por(input logic [4:0] c);
        int k;
        @(posedge clk);
        rst <= 1'b1;
        cfg <= c;
        wt(10);
        chk(8'(poe), 8'h00);
        chk(8'({host_mode, energy_saving_strap, uplink_lamp_select, loop_detect_strap,
            micro_enable}), 8'h19);
        @(posedge clk);
        rst <= 1'b0;
        k = 0;
        while (straps_valid !== 1'b1 && k < 20)
        begin
            wt(1);
            k++;
        end
        wt(2);
        chk(8'({host_mode, energy_saving_strap, uplink_lamp_select, loop_detect_strap,
            micro_enable}), 8'(c));
    endtask
    task t_hold;
        logic [4:0] c;
        c = cfg;
        @(posedge clk);
        cfg <= ~c;
        wt(8);
        chk(8'({host_mode, energy_saving_strap, uplink_lamp_select, loop_detect_strap,
            micro_enable}), 8'(c));
        @(posedge clk);
        cfg <= c;
        wt(4);
    endtask
    task t_slave;
        @(posedge clk);
        core_slave_tx_en <= 1'b1;
        core_slave_tx_data <= 1'b1;
        host_mosi <= 1'b1;
        host_sck <= 1'b1;
        wt(5);
        chk(8'({slave_selected, poe[3]}), 8'h00);
        @(posedge clk);
        host_sel_n <= 1'b0;
        wt(5);
        chk(8'({slave_selected, poe[3], pin[3], slave_clk, slave_data_in, poe[0], mem_data_in}),
            8'h7c);
        @(posedge clk);
        core_slave_tx_data <= 1'b0;
        host_mosi <= 1'b0;
        wt(5);
        chk(8'({pin[3], slave_data_in}), 8'h00);
        @(posedge clk);
        host_sel_n <= 1'b1;
        core_slave_tx_en <= 1'b0;
        wt(5);
    endtask
    task t_outs;
        @(posedge clk);
        core_lamp_on <= 8'h5a;
        core_uplink_data <= 8'h3c;
        core_flash_select <= 1'b1;
        core_flash_clk <= 1'b1;
        flash_data_in <= 1'b1;
        core_console_tx <= 1'b1;
        console_receive <= 1'b0;
        core_test_out_en <= 1'b1;
        wt(5);
        chk(uplink_pin_out, cfg[2] ? 8'ha5 : 8'h3c);
        chk(8'({pin[5], flash_clock_out, flash_data_out, flash_din}), 8'h05);
        chk(8'({pin[4], console_rx, pin[6], poe[6]}), 8'h09);
    endtask
    task t_jtag;
        logic [7:0] v;
        v = 8'hb4;
        wt(5);
        chk({7'h00, test_ctrl_in_reset}, 8'h01);
        chk(test_shift, 8'h00);
        @(posedge clk);
        test_reset_n <= 1'b1;
        wt(5);
        chk(8'(test_ctrl_in_reset), 8'h00);
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge clk);
            test_data_in <= v[i];
            test_clk <= 1'b0;
            wt(5);
            @(posedge clk);
            test_clk <= 1'b1;
            wt(5);
        end
        chk(test_shift, v);
        @(posedge clk);
        test_reset_n <= 1'b0;
        test_clk <= 1'b0;
        wt(5);
        chk(test_shift, 8'h00);
    endtask
    task t_mem;
        @(posedge clk);
        core_mem_read <= 1'b1;
        core_mem_data <= 1'b1;
        core_mem_clk <= 1'b1;
        mem_talk <= 1'b1;
        mem_bit <= 1'b1;
        wt(5);
        chk(8'({pin[0], poe[0], pin[1], pin[2], poe[3], mem_data_in, slave_data_in,
            slave_selected}), 8'hf4);
        @(posedge clk);
        mem_bit <= 1'b0;
        core_mem_data <= 1'b0;
        wt(5);
        chk(8'({pin[2], mem_data_in}), 8'h00);
        @(posedge clk);
        mem_talk <= 1'b0;
        core_mem_read <= 1'b0;
        wt(3);
    endtask
    initial
    begin
        por(5'h16);
        t_hold;
        t_slave;
        t_outs;
        t_jtag;
        por(5'h09);
        t_mem;
        t_outs;
        t_hold;
        test_done;
    end
endmodule // tb
`default_nettype wire
